// >>> common/hbsel_pkg.sv
// shared constants for the host bus resource selection block
`default_nettype none
package hbsel_pkg;
  // ----------------------------------------
  // host channel and line counts, defaults, forbidden channel and supported lines
  // ----------------------------------------
  localparam int DMA_CHANNELS = 8;
  localparam int IRQ_LINES = 16;
  localparam logic [2:0] DMA_CH_FORBIDDEN = 3'h4;
  localparam logic [2:0] DMA_A_DEFAULT = 3'h6;
  localparam logic [2:0] DMA_B_DEFAULT = 3'h7;
  localparam logic [3:0] IRQ_DEFAULT = 4'hA;
  localparam logic [15:0] IRQ_SUPPORTED = 16'hDEF8;
  // ----------------------------------------
  // address window
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam int BASE_LSB = 5;
  localparam logic [4:0] BASE_DEFAULT = 5'h11;
endpackage
`default_nettype wire

// >>> core/hbsel_route.sv
// one dma path: request routing and acknowledge selection for a channel number
`timescale 1ns/10ps
`default_nettype none
module hbsel_route
(
  // ---- selection
  input wire logic [2:0] chan,
  input wire logic active,
  // ---- path side
  input wire logic req,
  output logic ack,
  // ---- host side
  output logic [7:0] reqOut,
  output logic [7:0] reqOe,
  input wire logic [7:0] ackIn
);
  logic valid;
  assign valid = (chan != hbsel_pkg::DMA_CH_FORBIDDEN);
  always_comb
  begin
    reqOut = 8'h00;
    reqOe = 8'h00;
    ack = 1'b0;
    if (active && valid)
    begin
      reqOut[chan] = req;
      reqOe[chan] = 1'b1;
      ack = ~ackIn[chan];
    end
  end
endmodule
`default_nettype wire

// >>> core/hbsel_top.sv
// host bus resource selection: io window decode, dma path routing, shared irq gating
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/10ps
`default_nettype none
module hbsel_top
(
  // ---- clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // ---- configuration
  input wire logic [4:0] baseSel,
  input wire logic [2:0] dmaChanA,
  input wire logic [2:0] dmaChanB,
  input wire logic [3:0] irqSel,
  input wire logic dma_global_enable,
  input wire logic dualDma,
  input wire logic irq_master_enable,
  input wire logic transfer_count_irq_enable,
  input wire logic completion_irq_enable,
  // ---- host io address
  input wire logic [9:0] ioAddr,
  input wire logic ioCycle,
  output logic ioHit,
  // ---- internal dma and irq sources
  input wire logic dmaReqA,
  input wire logic dmaReqB,
  input wire logic irqPending,
  output logic dmaAckA,
  output logic dmaAckB,
  // ---- host dma pins, acknowledges active low
  input wire logic [7:0] hostAckIn_n,
  output logic [7:0] hostReqOut,
  output logic [7:0] hostReqOe,
  // ---- host irq pins
  output logic [15:0] hostIrqOut,
  output logic [15:0] hostIrqOe
);
  // ----------------------------------------
  // path and line selection
  // ----------------------------------------
  logic [7:0] rOutA;
  logic [7:0] rOeA;
  logic [7:0] rOutB;
  logic [7:0] rOeB;
  logic ackA;
  logic ackB;
  logic pathAOn;
  logic pathBOn;
  logic irqOn;
  logic irqLineOk;
  logic [3:0] irqLine;
  logic next_ioHit;
  logic next_dmaAckA;
  logic next_dmaAckB;
  logic [7:0] next_hostReqOut;
  logic [7:0] next_hostReqOe;
  logic [15:0] next_hostIrqOut;
  logic [15:0] next_hostIrqOe;

  function automatic logic chanOk(input logic [2:0] ch);
    chanOk = (ch != hbsel_pkg::DMA_CH_FORBIDDEN);
  endfunction

  // one-hot mask of a host irq line number
  function automatic logic [15:0] lineMask(input logic [3:0] line);
    lineMask = 16'h0000;
    lineMask[line] = 1'b1;
  endfunction

  // a refused channel leaves its path released instead of falling back
  // to a default, so a bad setting can never take another board's line

  assign pathAOn = dma_global_enable && chanOk(dmaChanA);
  // single mode drops b
  // b on a's channel is refused: both paths would fight over one request pin
  assign pathBOn = dma_global_enable && dualDma && chanOk(dmaChanB) && (dmaChanB != dmaChanA);
  assign irqLine = (irqSel == 4'h0) ? hbsel_pkg::IRQ_DEFAULT : irqSel;
  assign irqLineOk = hbsel_pkg::IRQ_SUPPORTED[irqLine];
  assign irqOn = irq_master_enable || transfer_count_irq_enable || completion_irq_enable;

  // ----------------------------------------
  // dma paths
  // ----------------------------------------
  hbsel_route routeA
  (
    .chan(dmaChanA),
    .active(pathAOn),
    .req(dmaReqA),
    .ack(ackA),
    .reqOut(rOutA),
    .reqOe(rOeA),
    .ackIn(hostAckIn_n)
  );

  hbsel_route routeB
  (
    .chan(dmaChanB),
    .active(pathBOn),
    .req(dmaReqB),
    .ack(ackB),
    .reqOut(rOutB),
    .reqOe(rOeB),
    .ackIn(hostAckIn_n)
  );

  // ----------------------------------------
  // io window decode
  // ----------------------------------------
  // address bits 4:0 pick a register inside the 32-byte window and
  // take no part in the compare
  always_comb
  begin
    next_ioHit = ioCycle && (ioAddr[hbsel_pkg::ADDR_W-1:hbsel_pkg::BASE_LSB] == baseSel);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ioHit <= 1'b0;
    end
    else
    begin
      ioHit <= next_ioHit;
    end
  end

  // ----------------------------------------
  // dma requests to the host
  // ----------------------------------------
  // the paths never share a channel, so or-ing them cannot merge two drivers
  always_comb
  begin
    next_hostReqOut = rOutA | rOutB;
    next_hostReqOe = rOeA | rOeB;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      hostReqOut <= 8'h00;
      hostReqOe <= 8'h00;
    end
    else
    begin
      hostReqOut <= next_hostReqOut;
      hostReqOe <= next_hostReqOe;
    end
  end

  // ----------------------------------------
  // dma acknowledges to the paths
  // ----------------------------------------
  always_comb
  begin
    // ack from the path's own channel
    next_dmaAckA = ackA;
    next_dmaAckB = ackB;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      dmaAckA <= 1'b0;
      dmaAckB <= 1'b0;
    end
    else
    begin
      dmaAckA <= next_dmaAckA;
      dmaAckB <= next_dmaAckB;
    end
  end

  // ----------------------------------------
  // shared irq line
  // ----------------------------------------
  // the pending level goes out only on the one selected line; every
  // other line stays released so other boards can use it
  always_comb
  begin
    next_hostIrqOut = 16'h0000;
    next_hostIrqOe = 16'h0000;
    if (irqOn && irqLineOk)
    begin
      next_hostIrqOe = lineMask(irqLine);
      next_hostIrqOut = irqPending ? lineMask(irqLine) : 16'h0000;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      hostIrqOut <= 16'h0000;
      hostIrqOe <= 16'h0000;
    end
    else
    begin
      hostIrqOut <= next_hostIrqOut;
      hostIrqOe <= next_hostIrqOe;
    end
  end
endmodule
`default_nettype wire

// >>> dv/hbsel_sva.sv
// checker on hbsel_top ports
`timescale 1ns/10ps
`default_nettype none
module hbsel_sva
(
  // ---- clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // ---- configuration
  input wire logic [4:0] baseSel,
  input wire logic [2:0] dmaChanA,
  input wire logic [2:0] dmaChanB,
  input wire logic [3:0] irqSel,
  input wire logic dma_global_enable,
  input wire logic dualDma,
  input wire logic irq_master_enable,
  input wire logic transfer_count_irq_enable,
  input wire logic completion_irq_enable,
  // ---- io window
  input wire logic [9:0] ioAddr,
  input wire logic ioCycle,
  input wire logic ioHit,
  // ---- dma and irq pins
  input wire logic dmaAckA,
  input wire logic [7:0] hostAckIn_n,
  input wire logic [7:0] hostReqOe,
  input wire logic [15:0] hostIrqOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire irqOn = irq_master_enable | transfer_count_irq_enable | completion_irq_enable;
  wire okA = dma_global_enable && dmaChanA != hbsel_pkg::DMA_CH_FORBIDDEN;
  wire irqStray = |(hostIrqOe & ~hbsel_pkg::IRQ_SUPPORTED);
  // path a is live and the host answers on that same channel
  sequence s_host_ack;
    okA && !hostAckIn_n[dmaChanA];
  endsequence
  // path b asked for the channel that path a already holds
  sequence s_b_on_a;
    dualDma && dmaChanB == dmaChanA;
  endsequence
  // irq enabled with the select left at zero
  sequence s_irq_default;
    irq_master_enable && irqSel == 4'h0;
  endsequence
  a_dma_off: assert property (!dma_global_enable |=> !hostReqOe) else $error("dma on");
  a_chan_four: assert property (!hostReqOe[4]) else $error("chan 4");
  a_path_a: assert property (okA |=> hostReqOe[$past(dmaChanA)]) else $error("path a");
  a_ack_pair: assert property (s_host_ack |=> dmaAckA) else $error("ack");
  a_b_refused: assert property (s_b_on_a |=> $onehot0(hostReqOe)) else $error("b on a");
  a_single_b: assert property (!dualDma |=> $onehot0(hostReqOe)) else $error("path b");
  a_irq_off: assert property (!irqOn |=> !hostIrqOe) else $error("irq on");
  a_irq_line: assert property ($onehot0(hostIrqOe) && !irqStray) else $error("line");
  a_irq_default: assert property (s_irq_default |=> hostIrqOe[hbsel_pkg::IRQ_DEFAULT]) else $error("default");
  a_io_hit: assert property (ioCycle && ioAddr[9:5] == baseSel |=> ioHit) else $error("io");
endmodule
bind hbsel_top hbsel_sva u_hbsel_sva (.*);
`default_nettype wire

// >>> dv/hbsel_host.sv
// host dma controller model
`timescale 1ns/10ps
`default_nettype none
module hbsel_host
(
  // ---- clock
  input wire logic clk_sys,
  // ---- request pins from the block
  input wire logic [7:0] hostReqOut,
  input wire logic [7:0] hostReqOe,
  // ---- acknowledge pins, active low
  output logic [7:0] hostAckIn_n
);
  always_ff @(posedge clk_sys) hostAckIn_n <= ~(hostReqOut & hostReqOe);
endmodule
`default_nettype wire

// >>> dv/hbsel_top_bench.sv
// self-checking bench for hbsel_top
`timescale 1ns/10ps
`default_nettype none
module hbsel_top_bench;
  logic clk_sys = 1'b0, nrst, ioCycle, ioHit, dmaReqA, dmaReqB, dmaAckA, dmaAckB, irqPending, dualDma;
  logic dma_global_enable, irq_master_enable, transfer_count_irq_enable, completion_irq_enable;
  logic [4:0] baseSel = hbsel_pkg::BASE_DEFAULT;
  logic [2:0] dmaChanA = hbsel_pkg::DMA_A_DEFAULT, dmaChanB = hbsel_pkg::DMA_B_DEFAULT;
  logic [3:0] irqSel;
  logic [9:0] ioAddr;
  logic [7:0] hostAckIn_n, hostReqOut, hostReqOe;
  logic [15:0] hostIrqOut, hostIrqOe;
  int failures = 0, samples_checked = 0;
  hbsel_top u_hbsel_top (.*);
  hbsel_host u_hbsel_host (.*);
  task chk(string n, logic [15:0] e, g);
    samples_checked++;
    failures += int'(g !== e);
    if (g !== e)
      $display("wrong value %s expected %h seen %h", n, e, g);
  endtask
  task step(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task complete_run;
    $display("%0d checks, %0d failures", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial forever #2 clk_sys = ~clk_sys;
  initial
  begin
    repeat (999) @(posedge clk_sys);
    failures++;
    complete_run;
  end
  initial
  begin
    {nrst, ioCycle, dmaReqA, dmaReqB, irqPending, dualDma, dma_global_enable, irqSel, ioAddr} = '0;
    {irq_master_enable, transfer_count_irq_enable, completion_irq_enable} = 3'h0;
    step(8);
    nrst = 1'b1;
    step(2);
    chk("released", 16'h0000, hostReqOe | hostIrqOe);
    {dma_global_enable, dualDma, dmaReqA, dmaReqB} = 4'hF;
    step(3);
    chk("dual", 16'h03C0, {dmaAckA, dmaAckB, hostReqOe});
    chk("request", 16'h00C0, hostReqOut);
    dmaChanB = hbsel_pkg::DMA_A_DEFAULT;
    step(1);
    chk("b on a", 16'h0040, hostReqOe);
    dmaChanB = hbsel_pkg::DMA_CH_FORBIDDEN;
    step(1);
    chk("b chan 4", 16'h0040, hostReqOe);
    dualDma = 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      dmaChanA = 3'(c);
      step(1);
      chk("single", c == 4 ? 16'h0000 : 16'(1 << c), hostReqOe);
    end
    dma_global_enable = 1'b0;
    step(1);
    chk("dma off", 16'h0000, hostReqOe);
    $display("dma test done");
    irqPending = 1'b1;
    // enables one at a time, then none, across every line
    for (int k = 0; k < 64; k++)
    begin
      irqSel = 4'(k);
      {irq_master_enable, transfer_count_irq_enable, completion_irq_enable} = 3'(1 << k / 16);
      step(1);
      chk("irq", k > 47 ? 16'h0000 : irqSel == 0 ? 16'h0400 : hbsel_pkg::IRQ_SUPPORTED[irqSel] ?
        16'(1 << irqSel) : 16'h0000, hostIrqOe);
      chk("irq out", 16'h0000, hostIrqOut ^ hostIrqOe);
    end
    // host keeps to the default line, clear of 6 and 14
    irqSel = 4'h0;
    irq_master_enable = 1'b1;
    irqPending = 1'b0;
    step(1);
    chk("irq held", 16'h0400, hostIrqOe);
    chk("irq level", 16'h0000, hostIrqOut);
    $display("irq test done");
    ioCycle = 1'b1;
    ioAddr = 10'h23F;
    step(1);
    chk("io hit", 16'h0001, ioHit);
    ioAddr = 10'h21F;
    step(1);
    chk("io miss", 16'h0000, ioHit);
    ioCycle = 1'b0;
    ioAddr = 10'h220;
    step(1);
    chk("io idle", 16'h0000, ioHit);
    $display("io test done");
    complete_run;
  end
endmodule
`default_nettype wire
